// *** src/fanrb_defs.svh ***
`ifndef FANRB_DEFS_SVH
`define FANRB_DEFS_SVH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define FANRB_ADDR_RAMP 8'hBF
`define FANRB_ADDR_HYST12 8'hC0
`define FANRB_ADDR_HYST34 8'hC1
`define FANRB_ADDR_SMOOTH 8'hC2
`define FANRB_RST_RAMP 8'h00
`define FANRB_RST_HYST 8'h44
`define FANRB_RST_SMOOTH 8'h00
`define FANRB_RD_UNMAPPED 8'h00

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define FANRB_RAMP_REG_LO 3:0
`define FANRB_RAMP_PROC_HI 7:4
`define FANRB_HYST_LO 3:0
`define FANRB_HYST_HI 7:4
`define FANRB_SPAN_ONE 2:0
`define FANRB_USE_ONE 3
`define FANRB_SPAN_TWO 6:4
`define FANRB_USE_TWO 7

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define FANRB_CLK_HZ 20000000
`define FANRB_RAMP_UNIT_MS 50
`define FANRB_SPAN0_MS 11800
`define FANRB_SPAN1_MS 7000
`define FANRB_SPAN2_MS 4400
`define FANRB_SPAN3_MS 3000
`define FANRB_SPAN4_MS 1600
`define FANRB_SPAN5_MS 800
`define FANRB_SPAN6_MS 600
`define FANRB_SPAN7_MS 400
`define FANRB_SMOOTH_SHIFT 4
`define FANRB_DUTY_FULL 8'hFF
`define FANRB_DUTY_ZERO 8'h00
`define FANRB_RAMP_STEP 8'h10

`endif

// *** src/fanrb_pkg.sv ***
package fanrb_pkg;

    typedef logic [7:0] fanrb_byte_t;
    typedef logic signed [7:0] fanrb_temp_t;
    typedef logic [3:0] fanrb_nib_t;
    typedef logic [2:0] fanrb_span_t;

    typedef enum logic [1:0] {
        FANRB_RAMP_HOLD = 2'b00,
        FANRB_RAMP_UP = 2'b01,
        FANRB_RAMP_DOWN = 2'b10
    } fanrb_ramp_dir_t;

endpackage : fanrb_pkg

// *** src/fanrb_smooth.sv ***
`timescale 1ns/1ns
`include "fanrb_defs.svh"

module fanrb_smooth #(
    parameter int CYC_PER_MS = `FANRB_CLK_HZ / 1000
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire fanrb_pkg::fanrb_temp_t i_temp,
    input wire fanrb_pkg::fanrb_span_t i_span,
    output fanrb_pkg::fanrb_temp_t o_filt
);
    import fanrb_pkg::*;

    // ------------------------------------------------------------
    // sample period per span
    // ------------------------------------------------------------
    // one-pole average; update period = span / 2^shift
    logic [31:0] period;
    always_comb begin
        int ms;
        ms = `FANRB_SPAN0_MS;
        unique case (i_span)
            3'h0: ms = `FANRB_SPAN0_MS;
            3'h1: ms = `FANRB_SPAN1_MS;
            3'h2: ms = `FANRB_SPAN2_MS;
            3'h3: ms = `FANRB_SPAN3_MS;
            3'h4: ms = `FANRB_SPAN4_MS;
            3'h5: ms = `FANRB_SPAN5_MS;
            3'h6: ms = `FANRB_SPAN6_MS;
            3'h7: ms = `FANRB_SPAN7_MS;
        endcase
        period = 32'((ms * CYC_PER_MS) >> `FANRB_SMOOTH_SHIFT);
    end

    // ------------------------------------------------------------
    // accumulator
    // ------------------------------------------------------------
    logic [31:0] cnt_r, cnt_nxt;
    logic signed [15:0] acc_r, acc_nxt;
    logic signed [16:0] diff;

    always_comb begin
        cnt_nxt = cnt_r + 32'd1;
        acc_nxt = acc_r;
        // signed cast first, so cold readings sign-extend instead of padding with zero
        diff = 17'(signed'({i_temp, 8'h00})) - 17'(acc_r);
        if (cnt_r + 32'd1 >= period) begin
            cnt_nxt = '0;
            // filtering on top of converter averaging
            acc_nxt = acc_r + 16'(diff >>> `FANRB_SMOOTH_SHIFT);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= '0;
            acc_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            acc_r <= acc_nxt;
        end
    end

    assign o_filt = acc_r[15:8];

endmodule : fanrb_smooth

// *** src/fanrb_top.sv ***
// How it works
// - ramp register low nibble: regulator-hot step delay, n times 50 ms
// - ramp register high nibble: processor-hot step delay, up to 750 ms
// - zero delay drives duty straight to full, no stepping
// - after boost, full duty held until temp below boost minus hysteresis
// - each hysteresis is unsigned 4 bits, 0 to 15 degrees
// - zones 1/2 register: zone 1 in bits 3:0, zone 2 in 7:4
// - zones 3/4 register: zone 3 in bits 3:0, zone 4 in 7:4
// - zone 1 use bit 3 selects filtered temp for limits and fan
// - zone 2 use bit 7 selects filtered temp for limits and fan
// - filtered temperature always computed and readable
// - ordinary reading stays unfiltered; limit and fan outputs smoothed only when selected
// - 3-bit span per zone selects 11.8 s down to 0.4 s
// - smoothing adds filtering beyond the converter's own averaging
`timescale 1ns/1ns
`include "fanrb_defs.svh"

module fanrb_top #(
    parameter int UNIT_CYCLES = `FANRB_CLK_HZ / 1000 * `FANRB_RAMP_UNIT_MS,
    parameter int CYC_PER_MS = `FANRB_CLK_HZ / 1000,
    parameter fanrb_pkg::fanrb_byte_t RAMP_STEP = `FANRB_RAMP_STEP
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire fanrb_pkg::fanrb_byte_t i_reg_addr,
    input wire logic i_reg_wr,
    input wire fanrb_pkg::fanrb_byte_t i_reg_wdata,
    output fanrb_pkg::fanrb_byte_t o_reg_rdata,
    input wire logic i_regulator_overtemp_input,
    input wire logic i_processor_overtemp_input,
    input wire fanrb_pkg::fanrb_temp_t i_temp_zone1,
    input wire fanrb_pkg::fanrb_temp_t i_temp_zone2,
    input wire fanrb_pkg::fanrb_temp_t i_temp_zone3,
    input wire fanrb_pkg::fanrb_temp_t i_temp_zone4,
    input wire fanrb_pkg::fanrb_temp_t i_boost_temp_zone1,
    input wire fanrb_pkg::fanrb_temp_t i_boost_temp_zone2,
    input wire fanrb_pkg::fanrb_temp_t i_boost_temp_zone3,
    input wire fanrb_pkg::fanrb_temp_t i_boost_temp_zone4,
    input wire logic i_limit_filter_sel_zone_one,
    input wire logic i_limit_filter_sel_zone_two,
    input wire logic i_fan_filter_sel_zone_one,
    input wire logic i_fan_filter_sel_zone_two,
    output fanrb_pkg::fanrb_byte_t o_regulator_ramp_duty,
    output fanrb_pkg::fanrb_byte_t o_processor_ramp_duty,
    output logic [3:0] o_boost_full,
    output fanrb_pkg::fanrb_temp_t o_reading_temp_zone1,
    output fanrb_pkg::fanrb_temp_t o_reading_temp_zone2,
    output fanrb_pkg::fanrb_temp_t o_filtered_temp_zone1,
    output fanrb_pkg::fanrb_temp_t o_filtered_temp_zone2,
    output fanrb_pkg::fanrb_temp_t o_limit_temp_zone1,
    output fanrb_pkg::fanrb_temp_t o_limit_temp_zone2,
    output fanrb_pkg::fanrb_temp_t o_fan_temp_zone1,
    output fanrb_pkg::fanrb_temp_t o_fan_temp_zone2
);
    import fanrb_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    fanrb_byte_t ramp_step_delay_ctrl_r, ramp_step_delay_ctrl_nxt;
    fanrb_byte_t boost_hysteresis_zones_12_r, boost_hysteresis_zones_12_nxt;
    fanrb_byte_t boost_hysteresis_zones_34_r, boost_hysteresis_zones_34_nxt;
    fanrb_byte_t spike_filter_ctrl_zones_12_r, spike_filter_ctrl_zones_12_nxt;
    fanrb_byte_t rdata_r, rdata_nxt;

    always_comb begin
        ramp_step_delay_ctrl_nxt = ramp_step_delay_ctrl_r;
        boost_hysteresis_zones_12_nxt = boost_hysteresis_zones_12_r;
        boost_hysteresis_zones_34_nxt = boost_hysteresis_zones_34_r;
        spike_filter_ctrl_zones_12_nxt = spike_filter_ctrl_zones_12_r;
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                `FANRB_ADDR_RAMP: ramp_step_delay_ctrl_nxt = i_reg_wdata;
                `FANRB_ADDR_HYST12: boost_hysteresis_zones_12_nxt = i_reg_wdata;
                `FANRB_ADDR_HYST34: boost_hysteresis_zones_34_nxt = i_reg_wdata;
                `FANRB_ADDR_SMOOTH: spike_filter_ctrl_zones_12_nxt = i_reg_wdata;
                default: ;
            endcase
        end
        unique case (i_reg_addr)
            `FANRB_ADDR_RAMP: rdata_nxt = ramp_step_delay_ctrl_r;
            `FANRB_ADDR_HYST12: rdata_nxt = boost_hysteresis_zones_12_r;
            `FANRB_ADDR_HYST34: rdata_nxt = boost_hysteresis_zones_34_r;
            `FANRB_ADDR_SMOOTH: rdata_nxt = spike_filter_ctrl_zones_12_r;
            default: rdata_nxt = `FANRB_RD_UNMAPPED;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ramp_step_delay_ctrl_r <= `FANRB_RST_RAMP;
            boost_hysteresis_zones_12_r <= `FANRB_RST_HYST;
            boost_hysteresis_zones_34_r <= `FANRB_RST_HYST;
            spike_filter_ctrl_zones_12_r <= `FANRB_RST_SMOOTH;
            rdata_r <= `FANRB_RD_UNMAPPED;
        end else begin
            ramp_step_delay_ctrl_r <= ramp_step_delay_ctrl_nxt;
            boost_hysteresis_zones_12_r <= boost_hysteresis_zones_12_nxt;
            boost_hysteresis_zones_34_r <= boost_hysteresis_zones_34_nxt;
            spike_filter_ctrl_zones_12_r <= spike_filter_ctrl_zones_12_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign o_reg_rdata = rdata_r;

    // ------------------------------------------------------------
    // 50 ms unit tick, shared by both ramps
    // ------------------------------------------------------------
    logic [31:0] unit_cnt_r, unit_cnt_nxt;
    logic unit_tick;

    always_comb begin
        unit_tick = (unit_cnt_r + 32'd1 >= 32'(UNIT_CYCLES));
        unit_cnt_nxt = unit_tick ? '0 : unit_cnt_r + 32'd1;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            unit_cnt_r <= '0;
        end else begin
            unit_cnt_r <= unit_cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // ramps: index 0 regulator, 1 processor
    // ------------------------------------------------------------
    fanrb_nib_t ramp_code [2];
    logic ramp_hot [2];
    fanrb_byte_t ramp_duty [2];

    assign ramp_code[0] = ramp_step_delay_ctrl_r[`FANRB_RAMP_REG_LO];
    assign ramp_code[1] = ramp_step_delay_ctrl_r[`FANRB_RAMP_PROC_HI];
    assign ramp_hot[0] = i_regulator_overtemp_input;
    assign ramp_hot[1] = i_processor_overtemp_input;

    for (genvar r = 0; r < 2; r++) begin : g_ramp
        fanrb_byte_t duty_r, duty_nxt;
        fanrb_nib_t ticks_r, ticks_nxt;
        fanrb_ramp_dir_t dir;

        always_comb begin
            duty_nxt = duty_r;
            ticks_nxt = ticks_r;
            if (ramp_hot[r] && duty_r != `FANRB_DUTY_FULL) begin
                dir = FANRB_RAMP_UP;
            end else if (!ramp_hot[r] && duty_r != `FANRB_DUTY_ZERO) begin
                dir = FANRB_RAMP_DOWN;
            end else begin
                dir = FANRB_RAMP_HOLD;
            end
            if (ramp_code[r] == 4'h0) begin
                // no stepping at all
                duty_nxt = ramp_hot[r] ? `FANRB_DUTY_FULL : `FANRB_DUTY_ZERO;
                ticks_nxt = '0;
            end else if (dir == FANRB_RAMP_HOLD) begin
                ticks_nxt = '0;
            end else if (unit_tick) begin
                // one step per code x 50 ms
                if (ticks_r + 4'd1 >= ramp_code[r]) begin
                    ticks_nxt = '0;
                    unique case (dir)
                        FANRB_RAMP_UP: duty_nxt = (`FANRB_DUTY_FULL - duty_r < RAMP_STEP) ?
                            `FANRB_DUTY_FULL : duty_r + RAMP_STEP;
                        FANRB_RAMP_DOWN: duty_nxt = (duty_r < RAMP_STEP) ?
                            `FANRB_DUTY_ZERO : duty_r - RAMP_STEP;
                        default: ;
                    endcase
                end else begin
                    ticks_nxt = ticks_r + 4'd1;
                end
            end
        end

        always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                duty_r <= `FANRB_DUTY_ZERO;
                ticks_r <= '0;
            end else begin
                duty_r <= duty_nxt;
                ticks_r <= ticks_nxt;
            end
        end

        assign ramp_duty[r] = duty_r;
    end

    // ------------------------------------------------------------
    // spike smoothing, zones 1 and 2
    // ------------------------------------------------------------
    fanrb_temp_t raw_temp [2];
    fanrb_temp_t filt_temp [2];
    fanrb_span_t span [2];
    logic use_filt [2];
    logic lim_sel [2];
    logic fan_sel [2];

    assign raw_temp[0] = i_temp_zone1;
    assign raw_temp[1] = i_temp_zone2;
    assign span[0] = spike_filter_ctrl_zones_12_r[`FANRB_SPAN_ONE];
    assign span[1] = spike_filter_ctrl_zones_12_r[`FANRB_SPAN_TWO];
    assign use_filt[0] = spike_filter_ctrl_zones_12_r[`FANRB_USE_ONE];
    assign use_filt[1] = spike_filter_ctrl_zones_12_r[`FANRB_USE_TWO];
    assign lim_sel[0] = i_limit_filter_sel_zone_one;
    assign lim_sel[1] = i_limit_filter_sel_zone_two;
    assign fan_sel[0] = i_fan_filter_sel_zone_one;
    assign fan_sel[1] = i_fan_filter_sel_zone_two;

    fanrb_temp_t lim_nxt [2];
    fanrb_temp_t fan_nxt [2];
    fanrb_temp_t lim_r [2];
    fanrb_temp_t fan_r [2];
    fanrb_temp_t read_r [2];
    fanrb_temp_t filt_r [2];

    for (genvar z = 0; z < 2; z++) begin : g_smooth
        // runs regardless of the use bit so software can always read it
        fanrb_smooth #(
            .CYC_PER_MS(CYC_PER_MS)
        ) u_smooth (
            .i_clk(i_clk),
            .i_rst_n(i_rst_n),
            .i_temp(raw_temp[z]),
            .i_span(span[z]),
            .o_filt(filt_temp[z])
        );

        always_comb begin
            // use bit overrides the separate selects, hence they need it clear
            lim_nxt[z] = (use_filt[z] || lim_sel[z]) ? filt_temp[z] : raw_temp[z];
            fan_nxt[z] = (use_filt[z] || fan_sel[z]) ? filt_temp[z] : raw_temp[z];
        end

        always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                lim_r[z] <= '0;
                fan_r[z] <= '0;
                read_r[z] <= '0;
                filt_r[z] <= '0;
            end else begin
                lim_r[z] <= lim_nxt[z];
                fan_r[z] <= fan_nxt[z];
                read_r[z] <= raw_temp[z];
                filt_r[z] <= filt_temp[z];
            end
        end
    end

    // ------------------------------------------------------------
    // fan boost hysteresis, zones 1..4
    // ------------------------------------------------------------
    fanrb_temp_t boost_src [4];
    fanrb_temp_t boost_lim [4];
    fanrb_nib_t hyst [4];

    assign boost_src[0] = fan_nxt[0];
    assign boost_src[1] = fan_nxt[1];
    assign boost_src[2] = i_temp_zone3;
    assign boost_src[3] = i_temp_zone4;
    assign boost_lim[0] = i_boost_temp_zone1;
    assign boost_lim[1] = i_boost_temp_zone2;
    assign boost_lim[2] = i_boost_temp_zone3;
    assign boost_lim[3] = i_boost_temp_zone4;
    assign hyst[0] = boost_hysteresis_zones_12_r[`FANRB_HYST_LO];
    assign hyst[1] = boost_hysteresis_zones_12_r[`FANRB_HYST_HI];
    assign hyst[2] = boost_hysteresis_zones_34_r[`FANRB_HYST_LO];
    assign hyst[3] = boost_hysteresis_zones_34_r[`FANRB_HYST_HI];

    logic [3:0] boost_r, boost_nxt;

    for (genvar b = 0; b < 4; b++) begin : g_boost
        logic signed [9:0] release_pt;
        always_comb begin
            // widened so boost point minus 15 cannot wrap
            release_pt = 10'(boost_lim[b]) - 10'({6'h00, hyst[b]});
            boost_nxt[b] = boost_r[b];
            if (boost_src[b] > boost_lim[b]) begin
                boost_nxt[b] = 1'b1;
            end else if (10'(boost_src[b]) < release_pt) begin
                boost_nxt[b] = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            boost_r <= '0;
        end else begin
            boost_r <= boost_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_regulator_ramp_duty = ramp_duty[0];
    assign o_processor_ramp_duty = ramp_duty[1];
    assign o_boost_full = boost_r;
    assign o_reading_temp_zone1 = read_r[0];
    assign o_reading_temp_zone2 = read_r[1];
    assign o_filtered_temp_zone1 = filt_r[0];
    assign o_filtered_temp_zone2 = filt_r[1];
    assign o_limit_temp_zone1 = lim_r[0];
    assign o_limit_temp_zone2 = lim_r[1];
    assign o_fan_temp_zone1 = fan_r[0];
    assign o_fan_temp_zone2 = fan_r[1];

endmodule : fanrb_top

// *** sim/fanrb_hot_src.sv ***
`timescale 1ns/1ns

module fanrb_hot_src #(
    parameter int LAG = 2
) (
    input wire logic i_clk,
    input wire logic i_reg_req,
    input wire logic i_proc_req,
    output logic o_regulator_overtemp_input,
    output logic o_processor_overtemp_input
);
    // ------------------------------------------------------------
    // hot lines, launched off the falling edge
    // ------------------------------------------------------------
    // lag models a slow sensor; levels only, no glitches
    logic [LAG-1:0] rq_r = '0;
    logic [LAG-1:0] pq_r = '0;

    always @(negedge i_clk) begin
        rq_r <= {rq_r[LAG-2:0], i_reg_req};
        pq_r <= {pq_r[LAG-2:0], i_proc_req};
    end

    assign o_regulator_overtemp_input = rq_r[LAG-1];
    assign o_processor_overtemp_input = pq_r[LAG-1];
endmodule : fanrb_hot_src

// *** sim/fanrb_top_sva.sv ***
`timescale 1ns/1ns
`include "fanrb_defs.svh"

module fanrb_chk #(
    parameter int UNIT_CYCLES = 4,
    parameter fanrb_pkg::fanrb_byte_t RAMP_STEP = 8'h10
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire fanrb_pkg::fanrb_byte_t i_reg_addr,
    input wire logic i_reg_wr,
    input wire fanrb_pkg::fanrb_byte_t i_reg_wdata,
    input wire fanrb_pkg::fanrb_byte_t o_reg_rdata,
    input wire logic i_regulator_overtemp_input,
    input wire logic i_processor_overtemp_input,
    input wire fanrb_pkg::fanrb_temp_t i_temp_zone3,
    input wire fanrb_pkg::fanrb_temp_t i_boost_temp_zone3,
    input wire fanrb_pkg::fanrb_byte_t o_regulator_ramp_duty,
    input wire fanrb_pkg::fanrb_byte_t o_processor_ramp_duty,
    input wire logic [3:0] o_boost_full
);
    import fanrb_pkg::*;
    // ------------------------------------------------------------
    // shadow registers and step spacing counter
    // ------------------------------------------------------------
    fanrb_byte_t ramp_r, ramp_nxt, hyst_r, hyst_nxt, pd_r;
    logic [15:0] cnt_r, cnt_nxt;
    logic mapped;
    int h3;

    always_comb begin
        mapped = i_reg_addr inside {`FANRB_ADDR_RAMP, `FANRB_ADDR_HYST34, 8'hc0, 8'hc2};
        ramp_nxt = (i_reg_wr && i_reg_addr == `FANRB_ADDR_RAMP) ? i_reg_wdata : ramp_r;
        hyst_nxt = (i_reg_wr && i_reg_addr == `FANRB_ADDR_HYST34) ? i_reg_wdata : hyst_r;
        // saturates so a long idle never wraps into a false short gap
        cnt_nxt = (o_regulator_ramp_duty != pd_r) ? 16'h0000 : cnt_r + {15'h0000, cnt_r != 16'hffff};
        h3 = int'(i_boost_temp_zone3) - int'(hyst_r[3:0]);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ramp_r <= `FANRB_RST_RAMP;
            hyst_r <= `FANRB_RST_HYST;
            pd_r <= 8'h00;
            cnt_r <= 16'hffff;
        end else begin
            ramp_r <= ramp_nxt;
            hyst_r <= hyst_nxt;
            pd_r <= o_regulator_ramp_duty;
            cnt_r <= cnt_nxt;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    property p_wr_rd;
        (i_reg_wr && mapped) ##1 (i_reg_addr == $past(i_reg_addr)) |=>
            (o_reg_rdata == $past(i_reg_wdata, 2));
    endproperty
    a_wr_rd: assert property (p_wr_rd) else $error("readback differs from written byte");
    property p_unmapped;
        !mapped |=> (o_reg_rdata == 8'h00);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_reg_zero;
        (ramp_r[3:0] == 4'h0) |=>
            (o_regulator_ramp_duty == ($past(i_regulator_overtemp_input) ? 8'hff : 8'h00));
    endproperty
    a_reg_zero: assert property (p_reg_zero) else $error("regulator duty not immediate");
    property p_proc_zero;
        (ramp_r[7:4] == 4'h0) |=>
            (o_processor_ramp_duty == ($past(i_processor_overtemp_input) ? 8'hff : 8'h00));
    endproperty
    a_proc_zero: assert property (p_proc_zero) else $error("processor duty not immediate");
    property p_reg_step;
        (o_regulator_ramp_duty != pd_r) && ($past(ramp_r[3:0]) != 4'h0) |->
            (o_regulator_ramp_duty - pd_r == RAMP_STEP) || (pd_r - o_regulator_ramp_duty == RAMP_STEP)
            || (o_regulator_ramp_duty inside {8'h00, 8'hff});
    endproperty
    a_reg_step: assert property (p_reg_step) else $error("ramp step size wrong");
    property p_reg_gap;
        (o_regulator_ramp_duty != pd_r) && ($past(ramp_r[3:0]) != 4'h0) |->
            (int'(cnt_r) >= (int'($past(ramp_r[3:0])) - 1) * UNIT_CYCLES);
    endproperty
    a_reg_gap: assert property (p_reg_gap) else $error("ramp steps too close");
    property p_b3_set;
        (i_temp_zone3 > i_boost_temp_zone3) |=> o_boost_full[2];
    endproperty
    a_b3_set: assert property (p_b3_set) else $error("zone three boost not set");
    property p_b3_hold;
        o_boost_full[2] && (int'(i_temp_zone3) >= h3) |=> o_boost_full[2];
    endproperty
    a_b3_hold: assert property (p_b3_hold) else $error("zone three boost dropped early");
    property p_b3_clear;
        (int'(i_temp_zone3) < h3) |=> !o_boost_full[2];
    endproperty
    a_b3_clear: assert property (p_b3_clear) else $error("zone three boost held too long");

    c_ramp: cover property ((o_regulator_ramp_duty != pd_r) && ($past(ramp_r[3:0]) != 4'h0));
    c_boost: cover property ($fell(o_boost_full[2]));
    c_write: cover property (i_reg_wr ##1 !i_reg_wr);
endmodule : fanrb_chk

bind fanrb_top fanrb_chk #(.UNIT_CYCLES(UNIT_CYCLES), .RAMP_STEP(RAMP_STEP)) fanrb_chk_inst (.*);

// *** sim/test_fanrb_top.sv ***
`timescale 1ns/1ns
`include "fanrb_defs.svh"

module test_fanrb_top;
    import fanrb_pkg::*;
    localparam int UNIT = 4;
    localparam int CPM = 16;
    localparam int STEP = `FANRB_RAMP_STEP;
    localparam int SPAN_MS [8] = '{11800, 7000, 4400, 3000, 1600, 800, 600, 400};
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic wr = 1'b0, rq = 1'b0, pq = 1'b0, rhot, phot;
    logic [3:0] sel = 4'h0;
    logic [3:0] bfull;
    fanrb_byte_t addr = 8'h00, wdata = 8'h00, rdata, rduty, pduty;
    fanrb_temp_t t [4], b [4], rd1, rd2, f1, f2, l1, l2, ft1, ft2;
    fanrb_byte_t mreg [int];
    int n_mismatch = 0;
    int n_checks = 0;
    int seed = 32'hfb77_e1e1;
    int w, cd;

    always #25 i_clk = ~i_clk;

    fanrb_hot_src #(.LAG(2)) fanrb_hot_src_inst (.i_clk(i_clk), .i_reg_req(rq), .i_proc_req(pq),
        .o_regulator_overtemp_input(rhot), .o_processor_overtemp_input(phot));

    fanrb_top #(.UNIT_CYCLES(UNIT), .CYC_PER_MS(CPM)) fanrb_top_inst (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .i_regulator_overtemp_input(rhot), .i_processor_overtemp_input(phot),
        .i_temp_zone1(t[0]), .i_temp_zone2(t[1]), .i_temp_zone3(t[2]), .i_temp_zone4(t[3]),
        .i_boost_temp_zone1(b[0]), .i_boost_temp_zone2(b[1]), .i_boost_temp_zone3(b[2]),
        .i_boost_temp_zone4(b[3]), .i_limit_filter_sel_zone_one(sel[0]),
        .i_limit_filter_sel_zone_two(sel[1]), .i_fan_filter_sel_zone_one(sel[2]),
        .i_fan_filter_sel_zone_two(sel[3]), .o_regulator_ramp_duty(rduty),
        .o_processor_ramp_duty(pduty), .o_boost_full(bfull), .o_reading_temp_zone1(rd1),
        .o_reading_temp_zone2(rd2), .o_filtered_temp_zone1(f1), .o_filtered_temp_zone2(f2),
        .o_limit_temp_zone1(l1), .o_limit_temp_zone2(l2), .o_fan_temp_zone1(ft1),
        .o_fan_temp_zone2(ft2));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic reset_dut;
        i_rst_n = 1'b0;
        repeat (4) @(negedge i_clk);
        i_rst_n = 1'b1;
        mreg = '{8'hbf: 8'h00, 8'hc0: 8'h44, 8'hc1: 8'h44, 8'hc2: 8'h00};
    endtask : reset_dut

    task automatic wr_reg(input fanrb_byte_t a, input fanrb_byte_t d);
        @(negedge i_clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        if (mreg.exists(a)) mreg[a] = d;
        @(negedge i_clk);
        wr = 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input fanrb_byte_t a);
        @(negedge i_clk);
        addr = a;
        @(negedge i_clk);
        chk("rdata", rdata, mreg.exists(a) ? mreg[a] : 8'h00);
    endtask : rd_reg

    // step list from the rules, compared at each duty change
    task automatic ramp(input bit proc, input int code, input bit up);
        fanrb_byte_t q [$];
        fanrb_byte_t last;
        int v;
        v = up ? 0 : 255;
        while (v != (up ? 255 : 0)) begin
            if (code == 0) v = up ? 255 : 0;
            else v = up ? (v > 255 - STEP ? 255 : v + STEP) : (v < STEP ? 0 : v - STEP);
            q.push_back(v[7:0]);
        end
        if (proc) pq = up;
        else rq = up;
        last = proc ? pduty : rduty;
        for (int k = 0; q.size() > 0; k++) begin
            w = 0;
            while ((proc ? pduty : rduty) === last && w < 80) begin
                @(negedge i_clk);
                w++;
            end
            last = proc ? pduty : rduty;
            chk("duty", last, q.pop_front());
            if (k > 0) chk("step gap", w[15:0], code * UNIT);
        end
    endtask : ramp

    task automatic wait_f1;
        fanrb_temp_t s;
        s = f1;
        w = 0;
        while (f1 === s && w < 13000) begin
            @(negedge i_clk);
            w++;
        end
    endtask : wait_f1

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        for (int z = 0; z < 4; z++) begin
            t[z] = fanrb_temp_t'($random(seed) % 30);
            b[z] = 8'sd100;
        end
        reset_dut();
        foreach (mreg[a]) rd_reg(a);
        repeat (24) begin
            addr = ($random(seed) & 4) != 0 ? fanrb_byte_t'(8'hbf + ($random(seed) & 3))
                : fanrb_byte_t'($random(seed));
            wr_reg(addr, fanrb_byte_t'($random(seed)));
            rd_reg(addr);
        end
        reset_dut();
        foreach (mreg[a]) rd_reg(a);
        for (int i = 0; i < 4; i++) begin
            cd = i < 2 ? i : (i - 2) * 15;
            wr_reg(8'hbf, fanrb_byte_t'(i < 2 ? cd : cd << 4));
            ramp(i >= 2, cd, 1'b1);
            ramp(i >= 2, cd, 1'b0);
        end
        wr_reg(8'hc0, 8'h53);
        wr_reg(8'hc1, 8'hf0);
        for (int z = 0; z < 4; z++) begin
            w = int'((z < 2 ? mreg[8'hc0] : mreg[8'hc1]) >> (4 * (z % 2))) & 15;
            b[z] = 8'sd40;
            // above boost, then at boost minus hyst, then one degree lower
            for (int p = 0; p < 3; p++) begin
                t[z] = fanrb_temp_t'(p == 0 ? 45 : 41 - w - p);
                repeat (4) @(negedge i_clk);
                chk("boost", bfull[z], p < 2);
            end
            b[z] = 8'sd100;
        end
        // filter period per span code, use bit clear
        for (int c = 7; c >= 0; c--) begin
            wr_reg(8'hc2, fanrb_byte_t'(c));
            t[0] = (f1 > 0) ? -8'sd100 : 8'sd100;
            wait_f1();
            wait_f1();
            chk("filter period", w[15:0], SPAN_MS[c] * CPM / 16);
        end
        chk("reading one", rd1, t[0]);
        chk("fan one raw", ft1, t[0]);
        sel = 4'b0100;
        repeat (3) @(negedge i_clk);
        chk("fan one sel", ft1, f1);
        chk("limit one raw", l1, t[0]);
        sel = 4'b0000;
        wr_reg(8'hc2, 8'h88);
        t[1] = 8'sd50;
        repeat (3) @(negedge i_clk);
        chk("fan one filt", ft1, f1);
        chk("limit one filt", l1, f1);
        chk("fan two filt", ft2, f2);
        chk("limit two filt", l2, f2);
        chk("reading two", rd2, t[1]);
        test_done();
    end

    initial begin
        repeat (100000) @(posedge i_clk);
        n_mismatch++;
        test_done();
    end
endmodule : test_fanrb_top
